// >>> prfh_pkg.sv
// How it works
// - one enable bit per upper node; bits 0..30 map to nodes 32..62
// - local physical-bound packets are checked by async filter, then by the physical filter
// - physical filter bit clear sends request to async receive request context
// - per-node comparison only for sources on our own bus
// - remote-bus packets are acknowledged only when bit 31 is set
// - bit 31 survives host bus reset; other bits clear
// - set address writes ones to set, clear address to clear; reads give value
// - whole filter resets to zero
// - local async request accepted only when its async filter bit is set
`default_nettype none
package prfh_pkg;
   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [11:0] PHYS_NODE_FILTER_UPPER_SET = 12'h110;
   localparam logic [11:0] PHYS_NODE_FILTER_UPPER_CLEAR = 12'h114;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int STRB_W = 4;
   localparam logic [31:0] FILTER_RESET = 32'h0000_0000;
   localparam int ALL_BUSES_BIT = 31;
   localparam logic [31:0] ALL_BUSES_MASK = 32'h8000_0000;
   // ---------------------------------------------------------------
   // node numbering
   // ---------------------------------------------------------------
   localparam logic [5:0] UPPER_NODE_BASE = 6'h20;
   localparam logic [5:0] BROADCAST_NODE = 6'h3F;
   // ---------------------------------------------------------------
   // bus responses
   // ---------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : prfh_pkg
`default_nettype wire

// >>> prfh_filter.sv
`timescale 1ns/100ps
`default_nettype none
module prfh_filter
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic host_bus_reset_n,
   // axi4-lite write address
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // neighbouring filters
   input wire logic [31:0] async_filter_lo,
   input wire logic [31:0] async_filter_hi,
   input wire logic [31:0] phys_filter_lo,
   // incoming request
   input wire logic req_valid,
   input wire logic [5:0] req_src_node,
   input wire logic req_src_local,
   input wire logic req_to_phys,
   // routing decision
   output logic dec_valid,
   output logic dec_ack,
   output logic dec_phys_ctx,
   output logic async_rx_request_context,
   // filter state
   output logic [31:0] phys_node_filter_upper
);
   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   function automatic logic [1:0] addr_kind(input logic [11:0] a);
      // bit 1 set address, bit 0 clear address
      addr_kind = {a == prfh_pkg::PHYS_NODE_FILTER_UPPER_SET, a == prfh_pkg::PHYS_NODE_FILTER_UPPER_CLEAR};
   endfunction : addr_kind

   function automatic logic node_bit(input logic [31:0] lo, input logic [31:0] hi, input logic [5:0] n);
      if (n == prfh_pkg::BROADCAST_NODE)
      begin
         node_bit = 1'b0;
      end
      else if (n < prfh_pkg::UPPER_NODE_BASE)
      begin
         node_bit = lo[n[4:0]];
      end
      else
      begin
         node_bit = hi[n[4:0]];
      end
   endfunction : node_bit

   // ---------------------------------------------------------------
   // write channel state
   // ---------------------------------------------------------------
   logic aw_held_r, aw_held_nxt;
   logic w_held_r, w_held_nxt;
   logic [11:0] awaddr_r, awaddr_nxt;
   logic [31:0] wdata_r, wdata_nxt;
   logic [3:0] wstrb_r, wstrb_nxt;
   logic awready_r, awready_nxt;
   logic wready_r, wready_nxt;
   logic bvalid_r, bvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt;
   logic [31:0] filter_r, filter_nxt;
   logic do_write;
   logic [1:0] wkind;

   // ---------------------------------------------------------------
   // byte lane mask
   // ---------------------------------------------------------------
   logic [31:0] lane_mask;
   genvar gi;
   generate
      for (gi = 0; gi < prfh_pkg::STRB_W; gi++)
      begin : g_lane
         assign lane_mask[gi*8 +: 8] = {8{wstrb_r[gi]}};
      end
   endgenerate

   always_comb
   begin
      aw_held_nxt = aw_held_r;
      w_held_nxt = w_held_r;
      awaddr_nxt = awaddr_r;
      wdata_nxt = wdata_r;
      wstrb_nxt = wstrb_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      filter_nxt = filter_r;
      wkind = addr_kind(awaddr_r);
      do_write = aw_held_r && w_held_r && !bvalid_r;
      if (s_axi_awvalid && awready_r)
      begin
         aw_held_nxt = 1'b1;
         awaddr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_r)
      begin
         w_held_nxt = 1'b1;
         wdata_nxt = s_axi_wdata;
         wstrb_nxt = s_axi_wstrb;
      end
      if (bvalid_r && s_axi_bready)
      begin
         bvalid_nxt = 1'b0;
      end
      if (!host_bus_reset_n)
      begin
         filter_nxt = (filter_r & prfh_pkg::ALL_BUSES_MASK) | (prfh_pkg::FILTER_RESET & ~prfh_pkg::ALL_BUSES_MASK);
      end
      if (do_write)
      begin
         aw_held_nxt = 1'b0;
         w_held_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = (wkind == 2'h0) ? prfh_pkg::RESP_SLVERR : prfh_pkg::RESP_OKAY;
         if (wkind[1])
         begin
            filter_nxt = filter_nxt | (wdata_r & lane_mask);
         end
         else if (wkind[0])
         begin
            filter_nxt = filter_nxt & ~(wdata_r & lane_mask);
         end
      end
      awready_nxt = !aw_held_nxt && !bvalid_nxt;
      wready_nxt = !w_held_nxt && !bvalid_nxt;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         awaddr_r <= 12'h000;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
         awready_r <= 1'b0;
         wready_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= prfh_pkg::RESP_OKAY;
         filter_r <= prfh_pkg::FILTER_RESET;
      end
      else
      begin
         aw_held_r <= aw_held_nxt;
         w_held_r <= w_held_nxt;
         awaddr_r <= awaddr_nxt;
         wdata_r <= wdata_nxt;
         wstrb_r <= wstrb_nxt;
         awready_r <= awready_nxt;
         wready_r <= wready_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         filter_r <= filter_nxt;
      end
   end

   // ---------------------------------------------------------------
   // read channel
   // ---------------------------------------------------------------
   logic arready_r, arready_nxt;
   logic rvalid_r, rvalid_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [1:0] rresp_r, rresp_nxt;

   always_comb
   begin
      rvalid_nxt = rvalid_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      if (rvalid_r && s_axi_rready)
      begin
         rvalid_nxt = 1'b0;
      end
      if (s_axi_arvalid && arready_r)
      begin
         rvalid_nxt = 1'b1;
         if (addr_kind(s_axi_araddr) != 2'h0)
         begin
            rdata_nxt = filter_r;
            rresp_nxt = prfh_pkg::RESP_OKAY;
         end
         else
         begin
            rdata_nxt = 32'h0000_0000;
            rresp_nxt = prfh_pkg::RESP_SLVERR;
         end
      end
      arready_nxt = !rvalid_nxt;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= prfh_pkg::RESP_OKAY;
      end
      else
      begin
         arready_r <= arready_nxt;
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
      end
   end

   // ---------------------------------------------------------------
   // request routing
   // ---------------------------------------------------------------
   logic dvalid_r, dvalid_nxt;
   logic dack_r, dack_nxt;
   logic dphys_r, dphys_nxt;
   logic dasync_r, dasync_nxt;
   logic async_ok;
   logic phys_ok;

   always_comb
   begin
      async_ok = node_bit(async_filter_lo, async_filter_hi, req_src_node);
      phys_ok = node_bit(phys_filter_lo, filter_r, req_src_node);
      dvalid_nxt = req_valid;
      if (req_src_local)
      begin
         dack_nxt = req_valid && async_ok;
         dphys_nxt = req_valid && async_ok && req_to_phys && phys_ok;
      end
      else
      begin
         dack_nxt = req_valid && filter_r[prfh_pkg::ALL_BUSES_BIT];
         dphys_nxt = dack_nxt && req_to_phys;
      end
      dasync_nxt = dack_nxt && !dphys_nxt;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         dvalid_r <= 1'b0;
         dack_r <= 1'b0;
         dphys_r <= 1'b0;
         dasync_r <= 1'b0;
      end
      else
      begin
         dvalid_r <= dvalid_nxt;
         dack_r <= dack_nxt;
         dphys_r <= dphys_nxt;
         dasync_r <= dasync_nxt;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign dec_valid = dvalid_r;
   assign dec_ack = dack_r;
   assign dec_phys_ctx = dphys_r;
   assign async_rx_request_context = dasync_r;
   assign phys_node_filter_upper = filter_r;
endmodule : prfh_filter
`default_nettype wire

// >>> prfh_filter_chk.sv
`timescale 1ns/100ps
`default_nettype none
// -------------------------
// routing and filter checks
// -------------------------
module prfh_filter_chk
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic host_bus_reset_n,
   // observed
   input wire logic s_axi_bvalid,
   input wire logic [31:0] async_filter_hi,
   input wire logic req_valid,
   input wire logic [5:0] req_src_node,
   input wire logic req_src_local,
   input wire logic req_to_phys,
   input wire logic dec_valid,
   input wire logic dec_ack,
   input wire logic dec_phys_ctx,
   input wire logic async_rx_request_context,
   input wire logic [31:0] phys_node_filter_upper
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   wire logic up = req_valid && req_src_local && req_src_node[5] && req_src_node != 6'h3F;
   wire logic hit_a = async_filter_hi[req_src_node[4:0]];
   wire logic hit_p = phys_node_filter_upper[req_src_node[4:0]];
   wire logic all_b = phys_node_filter_upper[31];
   a_dec_timing: assert property (dec_valid == $past(req_valid)) else $error("bad latency");
   a_ctx_split: assert property (dec_valid |-> (dec_phys_ctx ^ async_rx_request_context) == dec_ack
      && !(dec_phys_ctx && async_rx_request_context)) else $error("bad split");
   a_idle_quiet: assert property (!dec_valid |-> !dec_ack && !dec_phys_ctx && !async_rx_request_context)
      else $error("decision without request");
   a_remote_ack: assert property (req_valid && !req_src_local |=> dec_ack == $past(all_b)) else $error("remote");
   a_remote_phys: assert property (req_valid && !req_src_local && req_to_phys |=> dec_phys_ctx == dec_ack)
      else $error("remote ctx");
   a_local_ack: assert property (up |=> dec_ack == $past(hit_a)) else $error("local ack");
   a_upper_route: assert property (up |=> dec_phys_ctx ==
      ($past(hit_a) && $past(hit_p) && $past(req_to_phys))) else $error("upper route");
   a_bus_reset: assert property (!host_bus_reset_n |=> $rose(s_axi_bvalid)
      || phys_node_filter_upper == ($past(phys_node_filter_upper) & 32'h8000_0000)) else $error("bus reset");
   a_filter_hold: assert property (!$stable(phys_node_filter_upper) |-> $rose(s_axi_bvalid)
      || !$past(host_bus_reset_n)) else $error("filter moved");
   cover property (dec_phys_ctx);
   cover property (async_rx_request_context);
   cover property (!host_bus_reset_n && all_b);
endmodule : prfh_filter_chk
bind prfh_filter prfh_filter_chk i_chk (.*);
`default_nettype wire

// >>> prfh_filter_tb.sv
`timescale 1ns/100ps
`default_nettype none
module prfh_filter_tb;
   // -------------------------
   // stimulus and dut
   // -------------------------
   logic aclk = 1'h0, aresetn = 1'h0, host_bus_reset_n = 1'h1, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
   logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic req_valid = 1'h0, req_src_local = 1'h0, req_to_phys = 1'h0;
   logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
   logic [31:0] s_axi_wdata = 32'h0, async_filter_lo = 32'h1, async_filter_hi = 32'h4000_0003;
   logic [31:0] phys_filter_lo = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [5:0] req_src_node = 6'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic dec_valid, dec_ack, dec_phys_ctx, async_rx_request_context;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata, phys_node_filter_upper;
   int n_errors = 0;
   int n_tests = 0;
   always #2.5 aclk = ~aclk;
   prfh_filter i_dut (.*);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
         if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
      end
      while (s_axi_bvalid !== 1'h1);
      s_axi_bready <= 1'h0;
      chk({30'h0, s_axi_bresp}, {30'h0, r});
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
      end
      while (s_axi_rvalid !== 1'h1);
      s_axi_rready <= 1'h0;
      chk(s_axi_rdata, e);
      chk({30'h0, s_axi_rresp}, {30'h0, r});
   endtask : rd
   task automatic rq(input logic [5:0] n, input logic l, input logic p, input logic [2:0] e);
      @(posedge aclk);
      req_src_node <= n;
      req_src_local <= l;
      req_to_phys <= p;
      req_valid <= 1'h1;
      @(posedge aclk);
      req_valid <= 1'h0;
      #1 chk({28'h0, dec_valid, dec_ack, dec_phys_ctx, async_rx_request_context}, {28'h0, 1'h1, e});
   endtask : rq
   task automatic complete_run;
      if (n_errors == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : complete_run
   initial
   begin
      repeat (2000) @(posedge aclk);
      n_errors++;
      complete_run;
   end
   initial
   begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'h1;
      rd(12'h110, 32'h0, 2'h0);
      wr(12'h110, 32'hC000_0003, 2'h0);
      rd(12'h114, 32'hC000_0003, 2'h0);
      wr(12'h114, 32'h0000_0002, 2'h0);
      rd(12'h110, 32'hC000_0001, 2'h0);
      wr(12'h11C, 32'hFFFF_FFFF, 2'h2);
      rd(12'h11C, 32'h0, 2'h2);
      rd(12'h110, 32'hC000_0001, 2'h0);
      rq(6'h20, 1'h1, 1'h1, 3'h6);
      rq(6'h20, 1'h1, 1'h0, 3'h5);
      rq(6'h3E, 1'h1, 1'h1, 3'h6);
      rq(6'h21, 1'h1, 1'h1, 3'h5);
      rq(6'h22, 1'h1, 1'h1, 3'h0);
      rq(6'h00, 1'h1, 1'h1, 3'h5);
      rq(6'h22, 1'h0, 1'h1, 3'h6);
      rq(6'h22, 1'h0, 1'h0, 3'h5);
      @(posedge aclk);
      host_bus_reset_n <= 1'h0;
      @(posedge aclk);
      host_bus_reset_n <= 1'h1;
      rd(12'h110, 32'h8000_0000, 2'h0);
      chk(phys_node_filter_upper, 32'h8000_0000);
      wr(12'h114, 32'h8000_0000, 2'h0);
      rq(6'h22, 1'h0, 1'h1, 3'h0);
      @(posedge aclk);
      s_axi_wstrb <= 4'h2;
      wr(12'h110, 32'hFFFF_FFFF, 2'h0);
      rd(12'h110, 32'h0000_FF00, 2'h0);
      chk(phys_node_filter_upper, 32'h0000_FF00);
      @(posedge aclk);
      phys_filter_lo <= 32'h0000_0001;
      rq(6'h00, 1'h1, 1'h1, 3'h6);
      complete_run;
   end
endmodule : prfh_filter_tb
`default_nettype wire
